// >>> eei_top.sv
// module: external edge interrupt unit with apb register slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module eei_top import eei_pkg::*; #(
    parameter int NUM_UNITS = EEI_NUM_UNITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [EEI_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic rmw_access,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2*NUM_UNITS-1:0] pin_i,
    output logic [2*NUM_UNITS-1:0] pin_o,
    output logic [2*NUM_UNITS-1:0] pin_oe,
    output logic [2*NUM_UNITS-1:0] ch_req_o,
    output logic irq_o
);

    localparam int NP = EEI_CH_PER_UNIT * NUM_UNITS;

    // the map has room for four control registers only
    if (NUM_UNITS < 1 || NUM_UNITS > EEI_NUM_UNITS) begin : g_units_chk
        $error("eei_top: NUM_UNITS must be 1..4");
    end

    logic [NUM_UNITS-1:0][7:0] ctrl_r;
    logic [NUM_UNITS-1:0][7:0] ctrl_nxt;
    logic [NP-1:0] dir_r;
    logic [NP-1:0] port_data_r;
    logic [NP-1:0] status_r;
    logic [NP-1:0] status_nxt;
    logic [NP-1:0] enable_r;
    logic [NP-1:0] enable_nxt;
    logic [NP-1:0] ch_req_r;
    logic [NP-1:0] ch_req_nxt;
    logic irq_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic pready_r;
    logic pslverr_r;
    logic rd_err;
    logic setup_cyc;
    logic wr_fire;
    logic wr_lane0;
    logic [2*NP-1:0] sel_vec;
    logic [NP-1:0] active_vec;
    logic [NP-1:0] level;
    logic [NP-1:0] hit;

    // ==========================================================
    // apb handshake: setup cycle latches answer, one access cycle completes
    assign setup_cyc = psel & ~penable;
    assign wr_fire = psel & penable & pready_r & pwrite;
    assign wr_lane0 = wr_fire & pstrb[0];

    // ==========================================================
    // edge detection
    always_comb begin
        for (int c = 0; c < NP; c++) begin
            sel_vec[2*c +: 2] = ctrl_r[c/2][eei_sel_pos(c) +: 2];
            active_vec[c] = ~dir_r[c];
        end
    end

    eei_edge_detect #(
        .WIDTH(NP)
    ) u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin_i(pin_i),
        .sel_i(sel_vec),
        .active_i(active_vec),
        .level_o(level),
        .hit_o(hit)
    );

    // ==========================================================
    // control registers: flags write-zero-to-clear, a set beats a clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        for (int u = 0; u < NUM_UNITS; u++) begin
            if (wr_lane0 && paddr == eei_ctrl_addr(u)) begin
                ctrl_nxt[u] = pwdata[7:0];
                ctrl_nxt[u][EEI_FLAG0_BIT] = ctrl_r[u][EEI_FLAG0_BIT] & pwdata[EEI_FLAG0_BIT];
                ctrl_nxt[u][EEI_FLAG1_BIT] = ctrl_r[u][EEI_FLAG1_BIT] & pwdata[EEI_FLAG1_BIT];
            end
        end
        for (int c = 0; c < NP; c++) begin
            if (hit[c]) begin
                ctrl_nxt[c/2][eei_flag_pos(c)] = 1'b1;
            end
        end
        for (int c = 0; c < NP; c++) begin
            ch_req_nxt[c] = ctrl_nxt[c/2][eei_flag_pos(c)] & ctrl_nxt[c/2][eei_en_pos(c)];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int u = 0; u < NUM_UNITS; u++) begin
                ctrl_r[u] <= EEI_CTRL_RST;
            end
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // request lines follow the same next value so they track flag and enable exactly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_req_r <= '0;
        end else begin
            ch_req_r <= ch_req_nxt;
        end
    end

    // ==========================================================
    // port direction and data latch; a high direction bit drives the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= NP'(EEI_PORT_RST);
            port_data_r <= NP'(EEI_PORT_RST);
        end else begin
            if (wr_lane0 && paddr == EEI_PORT_DIR_ADDR) begin
                dir_r <= pwdata[NP-1:0];
            end
            if (wr_lane0 && paddr == EEI_PORT_DATA_ADDR) begin
                port_data_r <= pwdata[NP-1:0];
            end
        end
    end

    // ==========================================================
    // sticky event status, write-one clear, enable, single level irq
    always_comb begin
        status_nxt = status_r;
        enable_nxt = enable_r;
        if (wr_lane0 && paddr == EEI_IRQ_CLEAR_ADDR) begin
            status_nxt = status_r & ~pwdata[NP-1:0];
        end
        status_nxt = status_nxt | hit;
        if (wr_lane0 && paddr == EEI_IRQ_ENABLE_ADDR) begin
            enable_nxt = pwdata[NP-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
            enable_r <= '0;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
            irq_r <= |(status_nxt & enable_nxt);
        end
    end

    // ==========================================================
    // read mux, evaluated in the setup cycle
    always_comb begin
        rd_nxt = '0;
        rd_err = 1'b1;
        for (int u = 0; u < NUM_UNITS; u++) begin
            if (paddr == eei_ctrl_addr(u)) begin
                rd_nxt[7:0] = ctrl_r[u];
                if (rmw_access) begin
                    rd_nxt[EEI_FLAG0_BIT] = 1'b1;
                    rd_nxt[EEI_FLAG1_BIT] = 1'b1;
                end
                rd_err = 1'b0;
            end
        end
        case (paddr)
            EEI_PORT_DIR_ADDR: begin
                rd_nxt[NP-1:0] = dir_r;
                rd_err = 1'b0;
            end
            EEI_PORT_DATA_ADDR: begin
                // live level for inputs regardless of request enable; rmw sees the latch
                rd_nxt[NP-1:0] = rmw_access ? port_data_r :
                                 ((dir_r & port_data_r) | (~dir_r & level));
                rd_err = 1'b0;
            end
            EEI_IRQ_STATUS_ADDR: begin
                rd_nxt[NP-1:0] = status_r;
                rd_err = 1'b0;
            end
            EEI_IRQ_CLEAR_ADDR: begin
                rd_err = 1'b0;
            end
            EEI_IRQ_ENABLE_ADDR: begin
                rd_nxt[NP-1:0] = enable_r;
                rd_err = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // one wait-free access cycle; read data frozen at setup, so no race with the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (setup_cyc) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pready_r <= 1'b1;
            pslverr_r <= rd_err;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_o = port_data_r;
    assign pin_oe = dir_r;
    assign ch_req_o = ch_req_r;
    assign irq_o = irq_r;

    // ==========================================================
    // assertions and covers on channel 0/1 of the first unit and on the irq output
    req_tracks_a: assert property (@(posedge pclk) disable iff (!presetn)
        ch_req_o[0] == (ctrl_r[0][EEI_FLAG0_BIT] & ctrl_r[0][EEI_EN0_BIT])
        && ch_req_o[1] == (ctrl_r[0][EEI_FLAG1_BIT] & ctrl_r[0][EEI_EN1_BIT]))
        else $error("request line differs from flag and enable");

    flag0_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] |=> ctrl_r[0][EEI_FLAG0_BIT])
        else $error("channel 0 flag not set after edge");

    flag1_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit[1] |=> ctrl_r[0][EEI_FLAG1_BIT])
        else $error("channel 1 flag not set after edge");

    sel_none_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_r[0][EEI_SEL0_LSB +: 2] == EEI_SEL_NONE) |=> !hit[0])
        else $error("edge seen with detection off");

    rise_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
        (level[0] && !$past(level[0]) && !dir_r[0]
         && ctrl_r[0][EEI_SEL0_LSB +: 2] == EEI_SEL_RISE) |=> hit[0])
        else $error("rising edge missed");

    fall_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!level[0] && $past(level[0]) && ctrl_r[0][EEI_SEL0_LSB +: 2] == EEI_SEL_RISE)
        |=> !hit[0])
        else $error("falling edge taken in rising mode");

    dir_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        dir_r[0] |=> !hit[0])
        else $error("output pin raised an edge event");

    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_lane0 && paddr == eei_ctrl_addr(0) && !pwdata[EEI_FLAG0_BIT] && !hit[0])
        |=> !ctrl_r[0][EEI_FLAG0_BIT])
        else $error("writing zero did not clear flag");

    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_lane0 && paddr == eei_ctrl_addr(0) && pwdata[EEI_FLAG0_BIT])
        |=> ctrl_r[0][EEI_FLAG0_BIT] == ($past(ctrl_r[0][EEI_FLAG0_BIT]) | $past(hit[0])))
        else $error("writing one changed flag");

    rmw_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && rmw_access && paddr == eei_ctrl_addr(0))
        |=> prdata[EEI_FLAG0_BIT] && prdata[EEI_FLAG1_BIT] && pready)
        else $error("rmw flag read not one");

    pin_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_cyc && !pwrite && !rmw_access && paddr == EEI_PORT_DATA_ADDR && !dir_r[0])
        |=> prdata[0] == $past(level[0]))
        else $error("port data read missed live pin");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_o == |(status_r & enable_r))
        else $error("irq output differs from status and enable");

    flag_set_c: cover property (@(posedge pclk) disable iff (!presetn)
        hit[0] ##1 ch_req_o[0]);
    flag_clr_c: cover property (@(posedge pclk) disable iff (!presetn)
        ch_req_o[0] ##1 !ch_req_o[0]);
    rmw_read_c: cover property (@(posedge pclk) disable iff (!presetn)
        setup_cyc && rmw_access && !pwrite);
    irq_c: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq_o));

endmodule // eei_top
`default_nettype wire

// >>> eei_pkg.sv
// package: constants and helpers for the external edge interrupt unit
`default_nettype none
package eei_pkg;

    // ==========================================================
    // geometry
    localparam int EEI_NUM_UNITS = 4;
    localparam int EEI_CH_PER_UNIT = 2;
    localparam int EEI_ADDR_W = 12;

    // ==========================================================
    // control register indexes; byte address is four times the index
    localparam logic [EEI_ADDR_W-1:0] EEI_CTRL_UNIT1_IDX = 12'h048;
    localparam logic [EEI_ADDR_W-1:0] EEI_CTRL_UNIT2_IDX = 12'h049;
    localparam logic [EEI_ADDR_W-1:0] EEI_CTRL_UNIT3_IDX = 12'h04A;
    localparam logic [EEI_ADDR_W-1:0] EEI_CTRL_UNIT4_IDX = 12'h04B;

    // ==========================================================
    // port and interrupt bookkeeping registers (byte addresses)
    localparam logic [EEI_ADDR_W-1:0] EEI_PORT_DIR_ADDR = 12'h100;
    localparam logic [EEI_ADDR_W-1:0] EEI_PORT_DATA_ADDR = 12'h104;
    localparam logic [EEI_ADDR_W-1:0] EEI_IRQ_STATUS_ADDR = 12'h108;
    localparam logic [EEI_ADDR_W-1:0] EEI_IRQ_CLEAR_ADDR = 12'h10C;
    localparam logic [EEI_ADDR_W-1:0] EEI_IRQ_ENABLE_ADDR = 12'h110;

    // ==========================================================
    // control register fields, channel 0 low nibble, channel 1 high nibble
    localparam int EEI_EN0_BIT = 0;
    localparam int EEI_SEL0_LSB = 1;
    localparam int EEI_FLAG0_BIT = 3;
    localparam int EEI_EN1_BIT = 4;
    localparam int EEI_SEL1_LSB = 5;
    localparam int EEI_FLAG1_BIT = 7;

    // ==========================================================
    // reset values
    localparam logic [7:0] EEI_CTRL_RST = 8'h00;
    localparam logic [7:0] EEI_PORT_RST = 8'h00;

    // ==========================================================
    // edge select encodings
    typedef enum logic [1:0] {
        EEI_SEL_NONE = 2'h0,
        EEI_SEL_RISE = 2'h1,
        EEI_SEL_FALL = 2'h2,
        EEI_SEL_BOTH = 2'h3
    } eei_sel_t;

    function automatic logic [EEI_ADDR_W-1:0] eei_ctrl_addr(input int unit);
        logic [EEI_ADDR_W-1:0] idx;
        idx = EEI_CTRL_UNIT1_IDX + EEI_ADDR_W'(unit);
        return {idx[EEI_ADDR_W-3:0], 2'h0};
    endfunction

    function automatic int eei_flag_pos(input int ch);
        return (ch % 2 == 1) ? EEI_FLAG1_BIT : EEI_FLAG0_BIT;
    endfunction

    function automatic int eei_sel_pos(input int ch);
        return (ch % 2 == 1) ? EEI_SEL1_LSB : EEI_SEL0_LSB;
    endfunction

    function automatic int eei_en_pos(input int ch);
        return (ch % 2 == 1) ? EEI_EN1_BIT : EEI_EN0_BIT;
    endfunction

    // true when the sample pair shows the selected edge
    function automatic logic eei_edge_hit(input logic [1:0] sel, input logic prev,
                                          input logic cur);
        case (sel)
            EEI_SEL_RISE: return cur & ~prev;
            EEI_SEL_FALL: return prev & ~cur;
            EEI_SEL_BOTH: return cur ^ prev;
            default: return 1'b0;
        endcase
    endfunction

endpackage
`default_nettype wire

// >>> eei_edge_detect.sv
// module: pin synchronisers and per-channel edge detectors
`timescale 1ns/100ps
`default_nettype none
module eei_edge_detect import eei_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [2*WIDTH-1:0] sel_i,
    input wire logic [WIDTH-1:0] active_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] hit_o
);

    if (WIDTH < 1) begin : g_width_chk
        $error("eei_edge_detect: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] prev_r;
    logic [WIDTH-1:0] hit_r;

    // ==========================================================
    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // ==========================================================
    // edge compare on consecutive synchronised samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                hit_r[i] <= active_i[i] & eei_edge_hit(sel_i[2*i +: 2], prev_r[i], sync2_r[i]);
            end
        end
    end

    assign level_o = sync2_r;
    assign hit_o = hit_r;

endmodule // eei_edge_detect
`default_nettype wire

// >>> eei_pin_src.sv
// partner model: external pin drivers seen through the shared port pins
`timescale 1ns/100ps
`default_nettype none
module eei_pin_src (
    input wire logic [7:0] src_lvl,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_lvl
);
    // ==========================================================
    // wire level
    // a pin driven by the device shows its port latch; otherwise the outside source wins
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & src_lvl);
endmodule // eei_pin_src
`default_nettype wire

// >>> tb_top.sv
// testbench: apb sequences against the external edge interrupt unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import eei_pkg::*;
    logic pclk;
    logic presetn;
    logic [EEI_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic rmw_access;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_i;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic [7:0] ch_req_o;
    logic irq_o;
    logic [7:0] src_lvl;
    logic [31:0] rdv;
    logic erv;
    int n_fail = 0;
    int num_checks = 0;

    eei_top u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .rmw_access(rmw_access), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .ch_req_o(ch_req_o), .irq_o(irq_o)
    );

    eei_pin_src u_src (.src_lvl(src_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_i));

    // ==========================================================
    // clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================================
    // helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s, input logic read_modify_write);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        rmw_access <= read_modify_write;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        rmw_access <= 1'b0;
        if (i == 16) begin
            n_fail++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hF, 1'b0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic read_modify_write);
        apb(1'b0, a, 8'h00, 4'hF, read_modify_write);
        chk(rdv, e);
    endtask

    function automatic logic [11:0] ca(input int u);
        return (EEI_CTRL_UNIT1_IDX + 12'(u)) << 2;
    endfunction

    // one pin edge, then flag, request, write-one, rmw read and clear
    task automatic edge_pin(input int c, input logic lvl, input logic [7:0] cfg,
                            input logic [7:0] fe);
        @(posedge pclk);
        src_lvl[c] <= lvl;
        repeat (3) @(posedge pclk);
        chk(32'(ch_req_o[c]), 32'h0);
        repeat (3) @(posedge pclk);
        chk(32'(ch_req_o[c]), 32'(fe != 8'h00));
        rdc(ca(c / 2), 32'(cfg | fe), 1'b0);
        wr(ca(c / 2), cfg | 8'h88);
        rdc(ca(c / 2), 32'(cfg | fe), 1'b0);
        rdc(ca(c / 2), 32'(cfg | 8'h88), 1'b1);
        wr(ca(c / 2), cfg);
        rdc(ca(c / 2), 32'(cfg), 1'b0);
        chk(32'(ch_req_o[c]), 32'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int c;
        int s;
        int sh;
        logic [7:0] cfg;
        presetn = 1'b0;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        rmw_access = 1'b0;
        src_lvl = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (c = 0; c < 4; c++) rdc(ca(c), 32'h0, 1'b0);
        rdc(EEI_PORT_DIR_ADDR, 32'h0, 1'b0);
        rdc(EEI_PORT_DATA_ADDR, 32'h0, 1'b0);
        rdc(EEI_IRQ_STATUS_ADDR, 32'h0, 1'b0);
        rdc(EEI_IRQ_ENABLE_ADDR, 32'h0, 1'b0);
        rdc(EEI_IRQ_CLEAR_ADDR, 32'h0, 1'b0);
        apb(1'b0, 12'h000, 8'h00, 4'hF, 1'b0);
        chk(32'(erv), 32'h1);
        chk(rdv, 32'h0);
        $display("test reset done");

        wr(EEI_PORT_DIR_ADDR, 8'h00);
        for (c = 0; c < 8; c++) begin
            for (s = 0; s < 4; s++) begin
                sh = (c % 2) * 4;
                cfg = 8'((s * 2 + 1) << sh);
                // select changes only with the request disabled
                wr(ca(c / 2), 8'((s * 2) << sh));
                wr(ca(c / 2), cfg);
                edge_pin(c, 1'b1, cfg, 8'(((s % 2) * 8) << sh));
                edge_pin(c, 1'b0, cfg, 8'(((s / 2) * 8) << sh));
            end
        end
        $display("test edges done");

        rdc(EEI_IRQ_STATUS_ADDR, 32'hFF, 1'b0);
        chk(32'(irq_o), 32'h0);
        wr(EEI_IRQ_ENABLE_ADDR, 8'h10);
        repeat (2) @(posedge pclk);
        chk(32'(irq_o), 32'h1);
        wr(EEI_IRQ_CLEAR_ADDR, 8'hEF);
        rdc(EEI_IRQ_STATUS_ADDR, 32'h10, 1'b0);
        chk(32'(irq_o), 32'h1);
        wr(EEI_IRQ_CLEAR_ADDR, 8'h10);
        rdc(EEI_IRQ_STATUS_ADDR, 32'h0, 1'b0);
        chk(32'(irq_o), 32'h0);
        $display("test interrupt done");

        for (c = 0; c < 4; c++) wr(ca(c), 8'h66);
        wr(EEI_IRQ_CLEAR_ADDR, 8'hFF);
        // pin 0 is an output that rises from its own latch: it must raise no event
        wr(EEI_PORT_DIR_ADDR, 8'hF1);
        wr(EEI_PORT_DATA_ADDR, 8'h5B);
        apb(1'b1, EEI_PORT_DIR_ADDR, 8'h00, 4'h0, 1'b0);
        rdc(EEI_PORT_DIR_ADDR, 32'hF1, 1'b0);
        @(posedge pclk);
        src_lvl <= 8'h03;
        repeat (6) @(posedge pclk);
        chk(32'(pin_oe), 32'hF1);
        chk(32'(pin_o), 32'h5B);
        rdc(EEI_PORT_DATA_ADDR, 32'h53, 1'b0);
        rdc(EEI_PORT_DATA_ADDR, 32'h5B, 1'b1);
        rdc(EEI_IRQ_STATUS_ADDR, 32'h02, 1'b0);
        rdc(ca(0), 32'hE6, 1'b0);
        chk(32'(ch_req_o), 32'h0);
        $display("test port done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
